// ===== design/tsg_pkg.sv
// tsg_pkg: constants and carrier types for the timer software event generator.
// assumes a 32-bit classic wishbone slave with byte addresses.
package tsg_pkg;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00; // direction, counting, update control
   localparam logic [7:0]  ADDR_IRQ_EN   = 8'h0C; // irq/dma enables
   localparam logic [7:0]  ADDR_STATUS   = 8'h10; // channel flags, write 0 clears
   localparam logic [7:0]  ADDR_EVGEN    = 8'h14;
   localparam logic [7:0]  ADDR_CHMODE1  = 8'h18;
   localparam logic [7:0]  ADDR_CHMODE2  = 8'h1C;
   localparam logic [7:0]  ADDR_COUNT    = 8'h24;
   localparam logic [7:0]  ADDR_PRESC    = 8'h28;
   localparam logic [7:0]  ADDR_RELOAD   = 8'h2C;
   localparam logic [7:0]  ADDR_CAP1     = 8'h34;
   localparam logic [7:0]  ADDR_EVSTAT   = 8'h50; // sticky events, cleared by read
   localparam logic [7:0]  ADDR_EVMASK   = 8'h54;
   localparam logic [15:0] RST_EVGEN     = 16'h0000;
   localparam logic [15:0] RST_CHMODE    = 16'h0000;
   localparam logic [15:0] RST_RELOAD    = 16'hFFFF;
   localparam int          BIT_UPD       = 0;
   localparam int          BIT_CH1       = 1;
   localparam int          BIT_CTRLUPD   = 5;
   localparam int          BIT_TRIG      = 6;
   localparam int          BIT_BRAKE     = 7;
   localparam int          CTRL_UPD_DIS  = 1;
   localparam int          CTRL_UPD_SRC  = 2;
   localparam int          CTRL_DOWN     = 4;
   localparam int          CTRL_CENTER   = 5;
   localparam int          NUM_CH        = 4;

   typedef struct packed {
      logic        update;
      logic [3:0]  chan;
      logic        ctrl_upd;
      logic        trig;
      logic        brake;
   } tsg_events_t;
endpackage

// ===== design/tsg_channel.sv
// tsg_channel: one capture/compare channel's flag and capture logic.
// assumes forced events and clears are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module tsg_channel (
   input  wire logic        clock,      // timer clock
   input  wire logic        srst,       // synchronous reset
   input  wire logic        is_input,   // channel configured as capture input
   input  wire logic        force_ev,   // forced channel event pulse
   input  wire logic [15:0] count,      // current counter value
   input  wire logic        flag_clr,   // software clear of event flag
   input  wire logic        over_clr,   // software clear of overcapture flag
   output logic             flag,       // channel event flag
   output logic             over,       // overcapture flag
   output logic [15:0]      capture     // captured counter value
);
   logic        flag_q, over_q;
   logic [15:0] cap_q;
   wire         set_over = force_ev & is_input & flag_q;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         flag_q <= 1'b0;
         over_q <= 1'b0;
         cap_q  <= 16'h0000;
      end
      else
      begin
         // set wins over a clear in the same cycle
         flag_q <= force_ev | (flag_q & ~flag_clr);
         over_q <= set_over | (over_q & ~over_clr);
         if (force_ev & is_input)
            cap_q <= count;
      end
   end
   assign flag    = flag_q;
   assign over    = over_q;
   assign capture = cap_q;
endmodule

// ===== design/tsg_top.sv
// tsg_top: software event generation for a general timer, wishbone register slave.
// assumes a classic wishbone master; one clock, synchronous reset.
// Operation
// - writing 1 to update_trigger reinitialises the counter and raises an update event.
// - an update event clears the prescaler counter and keeps the division factor.
// - a software update loads auto_reload_value when counting down, else clears the counter.
// - writing 1 to ch1_event_trigger forces a capture/compare event on channel 1.
// - in output mode a forced event sets the flag and raises enabled irq and dma.
// - in input mode a forced event captures the counter, sets the flag, raises enabled irq and dma.
// - a forced capture while the flag is already set also sets the overcapture flag.
// - channels 2 to 4 have trigger bits 2 to 4 acting like channel 1.
// - bit 5 raises a control update event, useful only for complementary channels.
// - bit 6 raises a trigger event and self-clears.
// - bit 7 raises a brake event and self-clears.
// - event generation sits at 0x14, resets to 0, is write-only, bits 15:8 reserved.
// - the channel mode register selects capture input or compare output per channel.
// - a software update acts only with update_source_select 0 and update_disable 0.
// - channel flags stay set until written 0, or in input mode until capture register read.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module tsg_top (
   input  wire logic        clock,        // 25 MHz timer clock
   input  wire logic        srst,         // synchronous reset, active high
   input  wire logic        wb_cyc_i,     // wishbone cycle
   input  wire logic        wb_stb_i,     // wishbone strobe
   input  wire logic        wb_we_i,      // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,     // byte address
   input  wire logic [3:0]  wb_sel_i,     // byte selects
   input  wire logic [31:0] wb_dat_i,     // write data
   output logic [31:0]      wb_dat_o,     // read data
   output logic             wb_ack_o,     // acknowledge
   output logic             irq,          // level interrupt
   output logic [3:0]       dma_req,      // per-channel dma request
   output logic             update_ev,    // update event pulse
   output logic             ctrl_upd_ev,  // control update pulse
   output logic             trig_ev,      // trigger event pulse
   output logic             brake_ev      // brake event pulse
);
   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic        ack_q;
   logic [31:0] rdat_q;
   wire         req     = wb_cyc_i & wb_stb_i & ~ack_q;
   wire         wr      = req & wb_we_i;
   wire         rd      = req & ~wb_we_i;
   wire  [15:0] wdat    = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                           wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
   wire         lo_sel  = wb_sel_i[0];
   wire         hi_sel  = wb_sel_i[1];
   wire         hit_ctrl  = wb_adr_i == tsg_pkg::ADDR_CTRL;
   wire         hit_ien   = wb_adr_i == tsg_pkg::ADDR_IRQ_EN;
   wire         hit_sts   = wb_adr_i == tsg_pkg::ADDR_STATUS;
   wire         hit_evg   = wb_adr_i == tsg_pkg::ADDR_EVGEN;
   wire         hit_cm1   = wb_adr_i == tsg_pkg::ADDR_CHMODE1;
   wire         hit_cm2   = wb_adr_i == tsg_pkg::ADDR_CHMODE2;
   wire         hit_cnt   = wb_adr_i == tsg_pkg::ADDR_COUNT;
   wire         hit_psc   = wb_adr_i == tsg_pkg::ADDR_PRESC;
   wire         hit_rld   = wb_adr_i == tsg_pkg::ADDR_RELOAD;
   wire         hit_cap1  = wb_adr_i == tsg_pkg::ADDR_CAP1;
   wire         hit_evs   = wb_adr_i == tsg_pkg::ADDR_EVSTAT;
   wire         hit_evm   = wb_adr_i == tsg_pkg::ADDR_EVMASK;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [15:0] ctrl_q, ien_q, cm1_q, cm2_q, rld_q, psc_q;
   logic [7:0]  evmask_q;
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ctrl_q   <= 16'h0000;
         ien_q    <= 16'h0000;
         cm1_q    <= tsg_pkg::RST_CHMODE;
         cm2_q    <= tsg_pkg::RST_CHMODE;
         rld_q    <= tsg_pkg::RST_RELOAD;
         psc_q    <= 16'h0000;
         evmask_q <= 8'h00;
      end
      else if (wr)
      begin
         if (hit_ctrl && lo_sel)
            ctrl_q <= wdat;
         if (hit_ien)
            ien_q <= wdat;
         if (hit_cm1)
            cm1_q <= wdat;
         if (hit_cm2)
            cm2_q <= wdat;
         if (hit_rld)
            rld_q <= wdat;
         if (hit_psc)
            psc_q <= wdat;
         if (hit_evm && lo_sel)
            evmask_q <= wdat[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event generation: write-only, self-clearing pulse register
   logic [7:0] evg_q;
   wire        evg_wr = wr & hit_evg & lo_sel;
   always_ff @(posedge clock)
   begin
      if (srst)
         evg_q <= tsg_pkg::RST_EVGEN[7:0];
      else if (evg_wr)
         evg_q <= wdat[7:0];
      else
         evg_q <= 8'h00;
   end

   wire upd_allowed = ~ctrl_q[tsg_pkg::CTRL_UPD_DIS] & ~ctrl_q[tsg_pkg::CTRL_UPD_SRC];
   tsg_pkg::tsg_events_t ev;
   assign ev.update   = evg_q[tsg_pkg::BIT_UPD] & upd_allowed;
   assign ev.chan     = evg_q[tsg_pkg::BIT_CH1 +: tsg_pkg::NUM_CH];
   assign ev.ctrl_upd = evg_q[tsg_pkg::BIT_CTRLUPD];
   assign ev.trig     = evg_q[tsg_pkg::BIT_TRIG];
   assign ev.brake    = evg_q[tsg_pkg::BIT_BRAKE];

   ////////////////////////////////////////////////////////////////////////////
   // counter and prescaler
   logic [15:0] cnt_q, pcnt_q;
   wire         down    = ctrl_q[tsg_pkg::CTRL_DOWN] & ~ctrl_q[tsg_pkg::CTRL_CENTER];
   wire         ptick   = pcnt_q == psc_q;
   wire         cnt_wr  = wr & hit_cnt;
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cnt_q  <= 16'h0000;
         pcnt_q <= 16'h0000;
      end
      else if (ev.update)
      begin
         pcnt_q <= 16'h0000;
         cnt_q  <= down ? rld_q : 16'h0000;
      end
      else
      begin
         pcnt_q <= ptick ? 16'h0000 : pcnt_q + 16'h0001;
         if (cnt_wr)
            cnt_q <= wdat;
         else if (ptick)
            cnt_q <= down ? (cnt_q == 16'h0000 ? rld_q : cnt_q - 16'h0001)
                          : (cnt_q == rld_q ? 16'h0000 : cnt_q + 16'h0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channels
   logic [3:0]  ch_flag, ch_over;
   logic [15:0] ch_cap [4];
   wire  [31:0] cmode  = {cm2_q, cm1_q};
   wire         sts_wr = wr & hit_sts;
   genvar g;
   generate
      for (g = 0; g < tsg_pkg::NUM_CH; g++)
      begin : g_ch
         wire is_in = cmode[g*8 +: 2] != 2'b00;
         wire fclr  = (sts_wr & lo_sel & ~wb_dat_i[g+1])
                    | (rd & (wb_adr_i == tsg_pkg::ADDR_CAP1 + 8'(g*4)) & is_in);
         tsg_channel u_ch (
            .clock    (clock),
            .srst     (srst),
            .is_input (is_in),
            .force_ev (ev.chan[g]),
            .count    (cnt_q),
            .flag_clr (fclr),
            .over_clr (sts_wr & hi_sel & ~wb_dat_i[g+9]),
            .flag     (ch_flag[g]),
            .over     (ch_over[g]),
            .capture  (ch_cap[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // sticky event status, clear on read
   logic [7:0] evs_q;
   wire  [7:0] ev_vec = {ev.brake, ev.trig, ev.ctrl_upd, ev.chan, ev.update};
   wire        evs_rd = rd & hit_evs;
   always_ff @(posedge clock)
   begin
      if (srst)
         evs_q <= 8'h00;
      else
         evs_q <= ev_vec | (evs_rd ? 8'h00 : evs_q); // new events win over the read clear
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux and outputs
   wire [15:0] sts_word = {3'b000, ch_over, 1'b0, 3'b000, ch_flag, 1'b0};
   wire [2:0]  cap_idx  = 3'(wb_adr_i[4:2] - 3'd5);
   wire        hit_cap  = wb_adr_i >= tsg_pkg::ADDR_CAP1 && wb_adr_i <= 8'h40;
   wire [15:0] rsel =
        hit_ctrl ? ctrl_q :
        hit_ien  ? ien_q :
        hit_sts  ? sts_word :
        hit_evg  ? 16'h0000 :
        hit_cm1  ? cm1_q :
        hit_cm2  ? cm2_q :
        hit_cnt  ? cnt_q :
        hit_psc  ? psc_q :
        hit_rld  ? rld_q :
        hit_cap  ? ch_cap[cap_idx[1:0]] :
        hit_evs  ? {8'h00, evs_q} :
        hit_evm  ? {8'h00, evmask_q} : 16'h0000;

   logic       irq_q;
   logic [3:0] dma_q;
   logic [3:0] pls_q;
   wire  [3:0] ch_ien  = ien_q[4:1];
   wire  [3:0] ch_den  = ien_q[12:9];
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
         irq_q  <= 1'b0;
         dma_q  <= 4'h0;
         pls_q  <= 4'h0;
      end
      else
      begin
         ack_q  <= req;
         rdat_q <= rd ? {16'h0000, rsel} : 32'h0000_0000;
         irq_q  <= |(evs_q & evmask_q) | |(ch_flag & ch_ien);
         dma_q  <= ev.chan & ch_den;
         pls_q  <= {ev.brake, ev.trig, ev.ctrl_upd, ev.update};
      end
   end
   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = rdat_q;
   assign irq         = irq_q;
   assign dma_req     = dma_q;
   assign update_ev   = pls_q[0];
   assign ctrl_upd_ev = pls_q[1];
   assign trig_ev     = pls_q[2];
   assign brake_ev    = pls_q[3];

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_trig_selfclear: assert property (@(posedge clock) disable iff (srst)
      evg_wr |=> ##1 (evg_q == 8'h00))
      else $error("trigger bits not self-cleared");
   a_update_gated: assert property (@(posedge clock) disable iff (srst)
      (evg_wr && wdat[0] && !upd_allowed) |=> ##1 !update_ev)
      else $error("update raised while gated");
   a_update_reload: assert property (@(posedge clock) disable iff (srst)
      (ev.update && down) |=> cnt_q == $past(rld_q))
      else $error("down counter not reloaded");
   a_update_clear: assert property (@(posedge clock) disable iff (srst)
      ev.update |=> (pcnt_q == 16'h0000))
      else $error("prescaler not cleared");
   a_ch_flag_set: assert property (@(posedge clock) disable iff (srst)
      ev.chan[0] |=> ch_flag[0])
      else $error("channel flag not set");
   a_ch_capture: assert property (@(posedge clock) disable iff (srst)
      (ev.chan[0] && cm1_q[1:0] != 2'b00) |=> ch_cap[0] == $past(cnt_q))
      else $error("capture value wrong");
   a_overcapture: assert property (@(posedge clock) disable iff (srst)
      (ev.chan[0] && ch_flag[0] && cm1_q[1:0] != 2'b00) |=> ch_over[0])
      else $error("overcapture not flagged");
   a_brake_pulse: assert property (@(posedge clock) disable iff (srst)
      (evg_wr && wdat[7]) |=> ##1 brake_ev ##1 !brake_ev)
      else $error("brake pulse wrong");
endmodule

// ===== verif/tsg_top_tb_top.sv
// tsg_top_tb_top: self-checking bench for the timer software event generator.
// assumes tsg_top as the only design and drives its wishbone port directly.
`timescale 1ns/1ps
module tsg_top_tb_top;
   typedef struct packed
   {
      logic        rd;
      logic [31:0] d;
   } tsg_note_t;

   logic        clock = 1'b0;
   logic        srst  = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic        ack, irq, upd, cupd, trg, brk;
   logic [3:0]  dma;
   logic [7:0]  evs;
   int          ev_cnt[8], snap[8];
   int          n_mismatch = 0, checks = 0, cycles = 0;
   tsg_note_t   exp_q[$];
   logic [31:0] cv, rv, pv, md;

   always #20 clock = ~clock;

   tsg_top dut (.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq(irq), .dma_req(dma), .update_ev(upd), .ctrl_upd_ev(cupd), .trig_ev(trg),
      .brake_ev(brk));

   assign evs = {dma, brk, trg, cupd, upd};

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one classic cycle; the note is queued before the request so the monitor finds it
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'h3;
      wdat <= w ? d : 32'h0;
      do @(posedge clock); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
      exp_q.push_back('{1'b0, 32'h0});
      wb_cycle(1'b1, a, d);
   endtask

   task automatic wb_read(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back('{1'b1, e});
      wb_cycle(1'b0, a, 32'h0);
   endtask

   // write the event register and count each event output's high cycles afterwards
   task automatic fire(input logic [31:0] bits, input logic [7:0] exp);
      snap = ev_cnt;
      wb_write(tsg_pkg::ADDR_EVGEN, bits);
      repeat (4) @(posedge clock);
      for (int i = 0; i < 8; i++)
         check(32'(ev_cnt[i] - snap[i]), {31'h0, exp[i]});
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clock);
      check({31'h0, irq}, {31'h0, e});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      cycles++;
      for (int i = 0; i < 8; i++)
         ev_cnt[i] += evs[i];
      if (ack === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'hDEAD, 32'h0);
         else if (exp_q[0].rd)
            check(rdat, exp_q[0].d);
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
      if (cycles > 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      void'($urandom(7161));
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      wb_read(tsg_pkg::ADDR_EVGEN, 32'(tsg_pkg::RST_EVGEN));
      wb_read(tsg_pkg::ADDR_CHMODE1, 32'(tsg_pkg::RST_CHMODE));
      wb_read(tsg_pkg::ADDR_RELOAD, 32'(tsg_pkg::RST_RELOAD));
      wb_read(8'h60, 32'h0);
      wb_write(tsg_pkg::ADDR_EVMASK, 32'hFF);
      // global events: update, control update, trigger, brake
      for (int i = 0; i < 8; i++)
      begin
         if (i == 0 || i > 4)
         begin
            fire(32'h1 << i, 8'h1 << (i == 0 ? 0 : i - 4));
            irq_is(1'b1);
            wb_read(tsg_pkg::ADDR_EVGEN, 32'h0);
            wb_read(tsg_pkg::ADDR_EVSTAT, 32'h1 << i);
            wb_read(tsg_pkg::ADDR_EVSTAT, 32'h0);
            irq_is(1'b0);
         end
      end
      fire(32'h0, 8'h00);
      fire(32'hFF00, 8'h00);
      wb_write(tsg_pkg::ADDR_EVMASK, 32'h0);
      fire(32'h40, 8'h04);
      irq_is(1'b0);
      wb_read(tsg_pkg::ADDR_EVSTAT, 32'h40);
      // update blocked by either gate bit
      wb_write(tsg_pkg::ADDR_CTRL, 32'h1 << tsg_pkg::CTRL_UPD_DIS);
      fire(32'h1, 8'h00);
      wb_write(tsg_pkg::ADDR_CTRL, 32'h1 << tsg_pkg::CTRL_UPD_SRC);
      fire(32'h1, 8'h00);
      wb_read(tsg_pkg::ADDR_EVSTAT, 32'h0);
      // down, up and center modes: counter reload and prescaler factor kept
      for (int m = 0; m < 3; m++)
      begin
         rv = $urandom & 32'hFFFF;
         cv = $urandom & 32'hFFFF;
         // slow prescale so the counter cannot tick before it is read back
         pv = ($urandom & 32'hFFFF) | 32'h0100;
         wb_write(tsg_pkg::ADDR_RELOAD, rv);
         wb_write(tsg_pkg::ADDR_COUNT, cv);
         wb_write(tsg_pkg::ADDR_PRESC, pv);
         wb_write(tsg_pkg::ADDR_CTRL, m == 0 ? 32'h1 << tsg_pkg::CTRL_DOWN :
                                      m == 1 ? 32'h0 : 32'h1 << tsg_pkg::CTRL_CENTER);
         fire(32'h1, 8'h01);
         wb_read(tsg_pkg::ADDR_COUNT, m == 0 ? rv : 32'h0);
         wb_read(tsg_pkg::ADDR_PRESC, pv);
         wb_read(tsg_pkg::ADDR_EVSTAT, 32'h1);
      end
      // slowest prescale restarted by an update: the counter holds still while channels capture
      wb_write(tsg_pkg::ADDR_PRESC, 32'hFFFF);
      fire(32'h1, 8'h01);
      wb_read(tsg_pkg::ADDR_EVSTAT, 32'h1);
      // channels: output mode, then input mode with overcapture
      for (int c = 0; c < 4; c++)
      begin
         // any nonzero direction select means input
         md = (($urandom % 3) + 1) << (c[0] ? 8 : 0);
         wb_write(tsg_pkg::ADDR_IRQ_EN, (32'h2 << c) | (32'h200 << c));
         fire(32'h2 << c, 8'h10 << c);
         irq_is(1'b1);
         wb_read(tsg_pkg::ADDR_STATUS, 32'h2 << c);
         wb_write(tsg_pkg::ADDR_STATUS, 32'h0);
         wb_read(tsg_pkg::ADDR_STATUS, 32'h0);
         wb_write(c < 2 ? tsg_pkg::ADDR_CHMODE1 : tsg_pkg::ADDR_CHMODE2, md);
         cv = $urandom & 32'hFFFF;
         wb_write(tsg_pkg::ADDR_COUNT, cv);
         fire(32'h2 << c, 8'h10 << c);
         wb_read(tsg_pkg::ADDR_STATUS, 32'h2 << c);
         cv = $urandom & 32'hFFFF;
         wb_write(tsg_pkg::ADDR_COUNT, cv);
         fire(32'h2 << c, 8'h10 << c);
         wb_read(tsg_pkg::ADDR_STATUS, (32'h2 << c) | (32'h200 << c));
         wb_read(8'(tsg_pkg::ADDR_CAP1 + 4 * c), cv);
         wb_read(tsg_pkg::ADDR_STATUS, 32'h200 << c);
         irq_is(1'b0);
         wb_write(tsg_pkg::ADDR_STATUS, 32'h0);
         wb_write(c < 2 ? tsg_pkg::ADDR_CHMODE1 : tsg_pkg::ADDR_CHMODE2, 32'h0);
         wb_read(tsg_pkg::ADDR_EVSTAT, 32'h2 << c);
      end
      repeat (4) @(posedge clock);
      stop_test();
   end
endmodule
